// *** logic/cie_execute.sv ***
// Execute stage for increment, skip, branch, OR and move instructions.
`timescale 1ns/10ps
`include "cie_defines.svh"
module cie_execute
  import cie_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic                 rstn,
  input  wire logic                 instr_valid,
  input  wire logic [`CIE_IW-1:0]   instr,
  input  wire logic [`CIE_DW-1:0]   file_rdata,
  input  wire logic [`CIE_DW-1:0]   status_in,
  output logic      [`CIE_FAW-1:0]  file_addr,
  output logic                      file_we,
  output logic      [`CIE_DW-1:0]   file_wdata,
  output logic                      z_we,
  output logic                      z_value,
  output logic      [`CIE_DW-1:0]   w_reg,
  output logic      [`CIE_PCW-1:0]  pc,
  output logic                      flush
);
  // --------------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------------
  cie_dec_if dif ();
  logic [`CIE_IW-1:0] eff_instr;
  logic               flush_q;

  // A flushed slot executes as a no-operation word.
  assign eff_instr = (flush_q || !instr_valid) ? `CIE_NOP_WORD : instr;

  cie_decoder u_dec (
    .instr (eff_instr),
    .dec   (dif)
  );

  // --------------------------------------------------------------------------
  // Datapath
  // --------------------------------------------------------------------------
  logic [`CIE_DW-1:0] w_q;
  logic [`CIE_PCW-1:0] pc_q;
  logic [`CIE_DW-1:0] w_d;
  logic [`CIE_PCW-1:0] pc_d;
  logic               flush_d;
  wire logic [`CIE_DW-1:0] inc_res = file_rdata + `CIE_ONE8;
  wire logic [`CIE_DW-1:0] orl_res = w_q | dif.k8;
  wire logic [`CIE_DW-1:0] orf_res = w_q | file_rdata;
  wire logic is_inc   = (dif.op == CIE_OP_INC);
  wire logic is_incsz = (dif.op == CIE_OP_INCSZ);
  wire logic is_orf   = (dif.op == CIE_OP_ORF);
  wire logic is_move_file_op  = (dif.op == CIE_OP_MOVE_FILE_OP);
  wire logic is_move_to_file_op = (dif.op == CIE_OP_MOVE_TO_FILE_OP);
  wire logic is_orl   = (dif.op == CIE_OP_ORL);
  wire logic is_br    = (dif.op == CIE_OP_BRANCH);
  wire logic has_dest = is_inc || is_incsz || is_orf || is_move_file_op;
  logic [`CIE_DW-1:0] result;

  always_comb begin
    case (dif.op)
      CIE_OP_INC:   result = inc_res;
      CIE_OP_INCSZ: result = inc_res;
      CIE_OP_ORF:   result = orf_res;
      CIE_OP_MOVE_FILE_OP:  result = file_rdata;
      CIE_OP_ORL:   result = orl_res;
      CIE_OP_MOVE_TO_FILE_OP: result = w_q;
      default:      result = `CIE_ZERO8;
    endcase
  end

  wire logic skip_take = is_incsz && (inc_res == `CIE_ZERO8);

  assign file_addr  = dif.faddr;
  // File write on d=1 or for move-to-file.
  assign file_we    = (has_dest && dif.dest_f) || is_move_to_file_op;
  assign file_wdata = result;
  // Z updates only for ops that affect it; skip, branch and move-to-file leave it.
  assign z_we    = is_inc || is_orf || is_move_file_op || is_orl;
  assign z_value = (result == `CIE_ZERO8);

  always_comb begin
    w_d = w_q;
    if ((has_dest && !dif.dest_f) || is_orl) begin
      w_d = result;
    end
  end

  // Branch and a taken skip (result zero) both discard the already fetched word, costing a second cycle.
  assign flush_d = is_br || skip_take;

  always_comb begin
    pc_d = pc_q + `CIE_PC_ONE;
    if (is_br) begin
      pc_d = {status_in[`CIE_STAT_PA_HI:`CIE_STAT_PA_LO], dif.k9};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      w_q     <= `CIE_W_RST;
      pc_q    <= `CIE_PC_RST;
      flush_q <= 1'b0;
    end else if (instr_valid) begin
      w_q     <= w_d;
      pc_q    <= pc_d;
      flush_q <= flush_d;
    end
  end

  assign w_reg = w_q;
  assign pc    = pc_q;
  assign flush = flush_q;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  chk_branch_target: assert property (@(posedge ref_clk) disable iff (!rstn)
    instr_valid && is_br |=>
      pc == {$past(status_in[`CIE_STAT_PA_HI:`CIE_STAT_PA_LO]), $past(dif.k9)})
    else $error("branch target wrong");
  chk_branch_flush: assert property (@(posedge ref_clk) disable iff (!rstn)
    instr_valid && is_br |-> !z_we ##1 flush)
    else $error("branch not two cycles or touched Z");
  chk_skip_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
    instr_valid && is_incsz && file_rdata == `CIE_ONES8 |=> flush)
    else $error("skip not taken");
  chk_skip_noflag: assert property (@(posedge ref_clk) disable iff (!rstn)
    is_incsz |-> !z_we && file_wdata == file_rdata + 8'h01)
    else $error("skip op changed flags");
  chk_flush_nop: assert property (@(posedge ref_clk) disable iff (!rstn)
    flush |-> !file_we && !z_we && dif.op == CIE_OP_NONE)
    else $error("flushed slot had effect");
  chk_dest_w: assert property (@(posedge ref_clk) disable iff (!rstn)
    instr_valid && has_dest && !dif.dest_f |=> w_reg == $past(result))
    else $error("W destination not written");
  chk_orl_w: assert property (@(posedge ref_clk) disable iff (!rstn)
    instr_valid && is_orl |=> w_reg == ($past(w_q) | $past(dif.k8)))
    else $error("OR literal wrong");
  chk_move_to_file_op_file: assert property (@(posedge ref_clk) disable iff (!rstn)
    is_move_to_file_op |-> file_we && file_wdata == w_reg && !z_we)
    else $error("move to file wrong");
  chk_zero_flag: assert property (@(posedge ref_clk) disable iff (!rstn)
    z_we |-> z_value == (file_wdata == 8'h00))
    else $error("zero flag wrong");
  chk_inc_flag: assert property (@(posedge ref_clk) disable iff (!rstn)
    is_inc |-> z_we && file_wdata == file_rdata + 8'h01)
    else $error("increment wrong");
  chk_orf_flag: assert property (@(posedge ref_clk) disable iff (!rstn)
    is_orf |-> z_we && file_wdata == (w_reg | file_rdata))
    else $error("OR register wrong");
  chk_move_file_op_flag: assert property (@(posedge ref_clk) disable iff (!rstn)
    is_move_file_op |-> z_we && file_wdata == file_rdata)
    else $error("move file wrong");

  // --------------------------------------------------------------------------
  // Sequencing and hold checks
  // --------------------------------------------------------------------------
  // A stalled fetch must leave every piece of state alone, or the fetcher and
  // the program counter would drift apart.
  chk_reset_state: assert property (@(posedge ref_clk)
    !rstn |=> w_reg == `CIE_W_RST && pc == `CIE_PC_RST && !flush)
    else $error("reset state wrong");
  chk_pc_step: assert property (@(posedge ref_clk) disable iff (!rstn)
    instr_valid && !is_br |=> pc == $past(pc) + `CIE_PC_ONE)
    else $error("pc did not step");
  chk_hold_idle: assert property (@(posedge ref_clk) disable iff (!rstn)
    !instr_valid |=> $stable(w_reg) && $stable(pc) && $stable(flush))
    else $error("state moved while idle");
  chk_skip_none: assert property (@(posedge ref_clk) disable iff (!rstn)
    instr_valid && is_incsz && inc_res != `CIE_ZERO8 |=> !flush)
    else $error("skip taken on nonzero");
  chk_flush_once: assert property (@(posedge ref_clk) disable iff (!rstn)
    instr_valid && flush |=> !flush)
    else $error("flush lasted too long");
  chk_dest_file: assert property (@(posedge ref_clk) disable iff (!rstn)
    has_dest && dif.dest_f |-> file_we)
    else $error("file destination not written");
  chk_dest_nofile: assert property (@(posedge ref_clk) disable iff (!rstn)
    has_dest && !dif.dest_f |-> !file_we)
    else $error("file written for W destination");
  chk_inc_w: assert property (@(posedge ref_clk) disable iff (!rstn)
    instr_valid && is_inc && !dif.dest_f |=> w_reg == $past(file_rdata) + `CIE_ONE8)
    else $error("increment into W wrong");
  chk_orl_nofile: assert property (@(posedge ref_clk) disable iff (!rstn)
    is_orl |-> !file_we && z_we)
    else $error("OR literal touched file");
  chk_move_to_file_op_w: assert property (@(posedge ref_clk) disable iff (!rstn)
    instr_valid && is_move_to_file_op |=> $stable(w_reg))
    else $error("move to file changed W");
  chk_move_file_op_test: assert property (@(posedge ref_clk) disable iff (!rstn)
    is_move_file_op && file_rdata == `CIE_ZERO8 |-> z_we && z_value)
    else $error("zero test missed");
  chk_inc_wrap: assert property (@(posedge ref_clk) disable iff (!rstn)
    is_inc && file_rdata == `CIE_ONES8 |-> z_value)
    else $error("wrap did not set zero");
  chk_br_nofile: assert property (@(posedge ref_clk) disable iff (!rstn)
    is_br |-> !file_we)
    else $error("branch wrote file");
  chk_br_w: assert property (@(posedge ref_clk) disable iff (!rstn)
    instr_valid && is_br |=> $stable(w_reg))
    else $error("branch changed W");
endmodule

// *** logic/cie_defines.svh ***
// Constants for the instruction execute block: opcode fields, widths and reset values.
`ifndef CIE_DEFINES_SVH
`define CIE_DEFINES_SVH

// ----------------------------------------------------------------------------
// Instruction word fields (12-bit instruction)
// ----------------------------------------------------------------------------
`define CIE_IW          12
`define CIE_DW          8
`define CIE_PCW         11
`define CIE_FAW         5
`define CIE_F_HI        4
`define CIE_D_BIT       5
`define CIE_K8_HI       7
`define CIE_K9_HI       8
`define CIE_STAT_PA_HI  6
`define CIE_STAT_PA_LO  5
`define CIE_STAT_Z      2

// ----------------------------------------------------------------------------
// Opcode patterns, compared against the masked upper bits
// ----------------------------------------------------------------------------
`define CIE_OP6_INCREMENT_FILE_OP    6'h0a
`define CIE_OP6_INCREMENT_SKIP_ZERO_OP  6'h0f
`define CIE_OP6_OR_REGISTER_OP   6'h04
`define CIE_OP6_MOVE_FILE_OP    6'h08
`define CIE_OP7_MOVE_TO_FILE_OP   7'h01
`define CIE_OP3_BRANCH_OP    3'h5
`define CIE_OP4_OR_LITERAL_OP   4'hd
`define CIE_NOP_WORD    12'h000

// ----------------------------------------------------------------------------
// Reset values and arithmetic constants
// ----------------------------------------------------------------------------
`define CIE_W_RST       8'h00
`define CIE_PC_RST      11'h000
`define CIE_ONE8        8'h01
`define CIE_ZERO8       8'h00
`define CIE_ONES8       8'hff
`define CIE_PC_ONE      11'h001

`endif

// *** logic/cie_pkg.sv ***
// Types shared by the instruction execute block.
package cie_pkg;
  typedef enum logic [2:0] {
    CIE_OP_NONE,
    CIE_OP_INC,
    CIE_OP_INCSZ,
    CIE_OP_BRANCH,
    CIE_OP_ORL,
    CIE_OP_ORF,
    CIE_OP_MOVE_TO_FILE_OP,
    CIE_OP_MOVE_FILE_OP
  } cie_op_e;
endpackage

// *** logic/cie_dec_if.sv ***
// Interface carrying the decoded instruction from decoder to the execute stage.
`timescale 1ns/10ps
`include "cie_defines.svh"
interface cie_dec_if;
  import cie_pkg::*;
  cie_op_e               op;
  logic                  dest_f;
  logic [`CIE_FAW-1:0]   faddr;
  logic [`CIE_DW-1:0]    k8;
  logic [`CIE_K9_HI:0]   k9;
  modport dec (output op, output dest_f, output faddr, output k8, output k9);
  modport exe (input op, input dest_f, input faddr, input k8, input k9);
endinterface

// *** logic/cie_decoder.sv ***
// Opcode decoder: splits an instruction word into operation and operand fields.
`timescale 1ns/10ps
`include "cie_defines.svh"
module cie_decoder
  import cie_pkg::*;
(
  input  wire logic [`CIE_IW-1:0] instr,
  cie_dec_if.dec                  dec
);
  wire logic [5:0] op6 = instr[`CIE_IW-1:`CIE_IW-6];
  wire logic [6:0] op7 = instr[`CIE_IW-1:`CIE_IW-7];
  wire logic [2:0] op3 = instr[`CIE_IW-1:`CIE_IW-3];
  wire logic [3:0] op4 = instr[`CIE_IW-1:`CIE_IW-4];

  assign dec.op = (op6 == `CIE_OP6_INCREMENT_FILE_OP)   ? CIE_OP_INC :
                  (op6 == `CIE_OP6_INCREMENT_SKIP_ZERO_OP) ? CIE_OP_INCSZ :
                  (op6 == `CIE_OP6_OR_REGISTER_OP)  ? CIE_OP_ORF :
                  (op6 == `CIE_OP6_MOVE_FILE_OP)   ? CIE_OP_MOVE_FILE_OP :
                  (op7 == `CIE_OP7_MOVE_TO_FILE_OP)  ? CIE_OP_MOVE_TO_FILE_OP :
                  (op3 == `CIE_OP3_BRANCH_OP)   ? CIE_OP_BRANCH :
                  (op4 == `CIE_OP4_OR_LITERAL_OP)  ? CIE_OP_ORL : CIE_OP_NONE;
  assign dec.dest_f = instr[`CIE_D_BIT];
  assign dec.faddr  = instr[`CIE_F_HI:0];
  assign dec.k8     = instr[`CIE_K8_HI:0];
  assign dec.k9     = instr[`CIE_K9_HI:0];
endmodule

// *** verification/cie_execute_bench.sv ***
// Self-checking bench for the instruction execute block.
`timescale 1ns/10ps
`include "cie_defines.svh"
module cie_execute_bench;
  import cie_pkg::*;
  typedef struct {
    logic        fwe;
    logic [7:0]  fwd;
    logic        zwe;
    logic        zv;
    logic [7:0]  w;
    logic [10:0] pc;
    logic        fl;
    logic [4:0]  fa;
  } cie_note_s;
  localparam logic [11:0] OPB [8] = '{12'h280, 12'h3c0, 12'h100, 12'h200,
                                      12'h020, 12'ha00, 12'hd00, 12'h000};
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        instr_valid = 1'b0;
  logic [11:0] instr = 12'h000;
  logic [7:0]  file_rdata = 8'h00;
  logic [7:0]  status_in = 8'h00;
  logic [4:0]  file_addr;
  logic        file_we;
  logic [7:0]  file_wdata;
  logic        z_we;
  logic        z_value;
  logic [7:0]  w_reg;
  logic [10:0] pc;
  logic        flush;
  cie_note_s   q [$];
  cie_note_s   mon_n;
  logic [7:0]  m_w = 8'h00;
  logic [10:0] m_pc = 11'h000;
  logic        m_fl = 1'b0;
  int          n_fail = 0;
  int          comparisons = 0;

  always #2 ref_clk = ~ref_clk;

  cie_execute u_dut (.ref_clk(ref_clk), .rstn(rstn), .instr_valid(instr_valid), .instr(instr),
    .file_rdata(file_rdata), .status_in(status_in), .file_addr(file_addr), .file_we(file_we),
    .file_wdata(file_wdata), .z_we(z_we), .z_value(z_value), .w_reg(w_reg), .pc(pc),
    .flush(flush));

  // ----------------------------------------------------------------------------
  // Driver with reference model
  // ----------------------------------------------------------------------------
  function automatic logic [11:0] mk(input int op, input logic d, input logic [8:0] k);
    if (op < 4) return OPB[op] | {6'h00, d, k[4:0]};
    if (op == 4) return OPB[4] | {7'h00, k[4:0]};
    if (op == 5) return OPB[5] | {3'h0, k};
    if (op == 6) return OPB[6] | {4'h0, k[7:0]};
    return 12'h000;
  endfunction

  task automatic step(input logic v, input logic [11:0] iw, input logic [7:0] fd,
                      input logic [7:0] st);
    cie_note_s n;
    logic      ex;
    logic      wsel;
    logic      br;
    logic      sk;
    logic [7:0] r;
    @(posedge ref_clk);
    #1;
    instr_valid = v;
    instr = iw;
    file_rdata = fd;
    status_in = st;
    ex = v && !m_fl;
    n = '{1'b0, 8'h00, 1'b0, 1'b0, m_w, m_pc, m_fl, (ex ? iw[4:0] : 5'h00)};
    r = 8'h00;
    wsel = 1'b0;
    sk = 1'b0;
    br = (iw[11:9] == 3'h5);
    casez (iw)
      12'b0010_10??_????, 12'b0011_11??_????: r = fd + 8'h01;
      12'b0001_00??_????: r = m_w | fd;
      12'b0010_00??_????: r = fd;
      12'b0000_001?_????: r = m_w;
      12'b1101_????_????: r = m_w | iw[7:0];
      default: r = 8'h00;
    endcase
    casez (iw)
      12'b0011_11??_????: begin
        n.fwe = ex && iw[5];
        wsel = !iw[5];
        sk = (r == 8'h00);
      end
      12'b0010_10??_????, 12'b0001_00??_????, 12'b0010_00??_????: begin
        n.fwe = ex && iw[5];
        n.zwe = ex;
        wsel = !iw[5];
      end
      12'b0000_001?_????: n.fwe = ex;
      12'b1101_????_????: begin
        n.zwe = ex;
        wsel = 1'b1;
      end
      default: wsel = 1'b0;
    endcase
    n.fwd = r;
    n.zv = (r == 8'h00);
    q.push_back(n);
    if (ex && wsel) m_w = r;
    if (v) m_pc = (ex && br) ? {st[6:5], iw[8:0]} : m_pc + 11'h001;
    if (v) m_fl = ex && (br || sk);
  endtask

  // ----------------------------------------------------------------------------
  // Monitor and compare
  // ----------------------------------------------------------------------------
  task automatic cmpb(input string nm, input logic e, input logic s);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s expected %b seen %b", nm, e, s);
    end
  endtask

  task automatic cmpv(input string nm, input logic [10:0] e, input logic [10:0] s);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  always @(negedge ref_clk) begin
    if (q.size() > 0) begin
      mon_n = q.pop_front();
      cmpv("file_addr", {6'h00, mon_n.fa}, {6'h00, file_addr});
      cmpb("file_we", mon_n.fwe, file_we);
      if (mon_n.fwe) cmpv("file_wdata", {3'h0, mon_n.fwd}, {3'h0, file_wdata});
      cmpb("z_we", mon_n.zwe, z_we);
      if (mon_n.zwe) cmpb("z_value", mon_n.zv, z_value);
      cmpv("w_reg", {3'h0, mon_n.w}, {3'h0, w_reg});
      cmpv("pc", mon_n.pc, pc);
      cmpb("flush", mon_n.fl, flush);
    end
  end

  task automatic report_and_stop;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  initial begin
    void'($urandom(32'h6afa4a4b));
    repeat (3) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    step(1'b1, mk(6, 1'b0, 9'h0a5), 8'h00, 8'h00);
    step(1'b1, mk(1, 1'b1, 9'h003), 8'hff, 8'h00);
    step(1'b1, mk(0, 1'b0, 9'h004), 8'h55, 8'h00);
    step(1'b1, mk(1, 1'b0, 9'h004), 8'h7f, 8'h00);
    step(1'b1, mk(0, 1'b0, 9'h01f), 8'hff, 8'h00);
    step(1'b1, mk(5, 1'b0, 9'h1ff), 8'h00, 8'h60);
    step(1'b1, mk(6, 1'b0, 9'h0ff), 8'h00, 8'h00);
    step(1'b1, mk(5, 1'b0, 9'h000), 8'h00, 8'h20);
    step(1'b0, mk(6, 1'b0, 9'h011), 8'h00, 8'h00);
    step(1'b1, mk(4, 1'b0, 9'h01f), 8'h00, 8'h00);
    step(1'b1, mk(3, 1'b1, 9'h008), 8'h00, 8'h00);
    step(1'b1, mk(2, 1'b0, 9'h002), 8'h81, 8'h00);
    repeat (400) step(($urandom % 8) != 0, mk($urandom % 8, 1'($urandom), 9'($urandom)),
                      8'($urandom % 3 == 0 ? 8'hff : $urandom), 8'($urandom));
    step(1'b0, 12'h000, 8'h00, 8'h00);
    repeat (2) @(posedge ref_clk);
    report_and_stop();
  end

  initial begin
    #8000;
    n_fail++;
    report_and_stop();
  end
endmodule
